// File: src/dcas_params.svh
`ifndef DCAS_PARAMS_SVH
`define DCAS_PARAMS_SVH
// Register block offsets, byte addresses on the AXI4-Lite port.
`define DCAS_PCR_OFS 8'h00
`define DCAS_CCR_OFS 8'h10
`define DCAS_BCR_OFS 8'h20
`define DCAS_ADR_OFS 8'h30
// Field positions.
`define DCAS_ROT_BIT 7
`define DCAS_END_BIT 7
`define DCAS_BUSY_BIT 6
// Reset values of the priority control fields.
`define DCAS_PCR_RST 4'h0
`define DCAS_ROT_RST 2'h0
// Bus response codes.
`define DCAS_RESP_OK 2'b00
`define DCAS_RESP_ERR 2'b10
`endif

// File: src/dcas_pkg.sv
package dcas_pkg;
   // Sequencer states.
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_REQ,
      ST_XFER,
      ST_DEAD,
      ST_GAP
   } dcas_state_e;

   // Per-channel transfer configuration, low nibble of the channel control register.
   typedef struct packed {
      logic up_down;
      logic three_state_bus_mode;
      logic burst;
      logic rw;
   } dcas_cfg_s;

   // Address and direction lines driven during a transfer.
   typedef struct packed {
      logic [15:0] addr;
      logic rw;
      logic oe;
   } dcas_bus_s;
endpackage : dcas_pkg

// File: src/dcas_top.sv
// What this block does
// - Three-state mode transfers request the bus on the three-state request, never halt.
// - The three-state request also goes out to stretch the processor clock.
// - Three-state mode never bursts; request is released after every byte.
// - A request competes only with its enable bit and zero-count flag both set.
// - The chosen channel stays latched for one byte, or the whole block in burst.
// - If the latched request drops, no byte moves until it rises again.
// - The serving channel's own request is blocked during its transfer.
// - Normal priority order is channel 0, 1, 2, 3.
// - Rotate mode favours the channel after the last served, that one last.
// - After reset rotate priority starts at channel 0.
// - Halt to halt channel change keeps halt request low with one dead cycle.
// - Three-state to three-state change returns the bus for two cycles.
// - Halt cycle steal gives the bus back between two bytes of one channel.
// - Busy sets when the channel's request is first latched, before its first byte, clears at block end.
// - Busy clears while the channel's request enable bit is 0.
// - Block end flag sets when the block completes and the count reaches 0.
// - Block end flag clears right after software reads its channel control register.
// - Busy and block end are readable; the zero-count flag is not.
// - Zero-count resets to 0, set by nonzero count write, cleared by 0.
// - With zero-count 0 the channel's requests are ignored despite enable.
// - Reset clears zero-count but leaves the byte count unchanged.
// - Requests are sampled on the rising edge of the transfer clock.
// - After grant, acknowledge, address and direction lines are driven.
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
`include "dcas_params.svh"

module dcas_top #(
   parameter int NCH = 4
) (
   // Clock and reset; aclk is the transfer clock, aresetn is the reset pin.
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write channels.
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read channels.
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Peripheral side.
   input wire logic [NCH-1:0] channel_request,
   output logic [NCH-1:0] transfer_ack_b,
   output logic transfer_strobe,
   // Processor bus side.
   input wire logic bus_grant_in,
   output logic halt_bus_request_n,
   output logic tsc_bus_request_n,
   output logic tsc_bus_request_out,
   output dcas_pkg::dcas_bus_s dma_bus
);

   ////////////////////////////////////////////////////////////////////////////
   // Helpers.

   // Picks the first set bit of elig starting at index start, wrapping round.
   function automatic logic [2:0] pick(input logic [3:0] elig, input logic [1:0] start);
      logic [2:0] res;
      logic [1:0] idx;
      res = 3'h0;
      for (int k = 3; k >= 0; k--) begin
         idx = start + 2'(k);
         if (elig[idx]) begin
            res = {1'b1, idx};
         end
      end
      return res;
   endfunction : pick

   // Merges the two low byte lanes of a write into a 16-bit register.
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] s);
      return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction : merge16

   ////////////////////////////////////////////////////////////////////////////
   // State.

   logic [NCH-1:0] req_s1, req_s;
   logic grant_s1, grant_s;
   logic [NCH-1:0] prio_en;
   logic rotate;
   dcas_pkg::dcas_cfg_s cfg [NCH];
   logic [15:0] bcount [NCH];
   logic [15:0] xaddr [NCH];
   logic [NCH-1:0] zero_flag, busy, end_flag;
   dcas_pkg::dcas_state_e state, next_state;
   logic [1:0] cur_ch, rot_ptr;
   logic block_own;
   logic [7:0] aw_q;
   logic [31:0] w_q;
   logic [3:0] ws_q;

   always_ff @(posedge aclk) begin
      req_s1 <= channel_request;
      req_s <= req_s1;
      grant_s1 <= bus_grant_in;
      grant_s <= grant_s1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register decode.

   wire wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   wire [3:0] wr_ch = 4'b0001 << aw_q[3:2];
   wire wr_pcr = wr_fire && aw_q == `DCAS_PCR_OFS;
   wire [3:0] wr_ccr = (wr_fire && aw_q[7:4] == `DCAS_CCR_OFS >> 4) ? wr_ch : 4'h0;
   wire [3:0] wr_bcr = (wr_fire && aw_q[7:4] == `DCAS_BCR_OFS >> 4) ? wr_ch : 4'h0;
   wire [3:0] wr_adr = (wr_fire && aw_q[7:4] == `DCAS_ADR_OFS >> 4) ? wr_ch : 4'h0;
   wire wr_hit = wr_pcr || (|wr_ccr) || (|wr_bcr) || (|wr_adr);
   wire rd_fire = s_axi_arvalid && s_axi_arready;
   wire [1:0] rd_ch = s_axi_araddr[3:2];
   wire rd_is_pcr = s_axi_araddr == `DCAS_PCR_OFS;
   wire rd_is_ccr = s_axi_araddr[7:4] == `DCAS_CCR_OFS >> 4 && s_axi_araddr[1:0] == 2'h0;
   wire rd_is_bcr = s_axi_araddr[7:4] == `DCAS_BCR_OFS >> 4 && s_axi_araddr[1:0] == 2'h0;
   wire rd_is_adr = s_axi_araddr[7:4] == `DCAS_ADR_OFS >> 4 && s_axi_araddr[1:0] == 2'h0;
   wire rd_hit = rd_is_pcr || rd_is_ccr || rd_is_bcr || rd_is_adr;
   wire [3:0] rd_ccr = (rd_fire && rd_is_ccr) ? 4'b0001 << rd_ch : 4'h0;
   wire [7:0] ccr_view = {end_flag[rd_ch], busy[rd_ch], 2'h0, cfg[rd_ch]};
   wire [31:0] rd_word = rd_is_pcr ? {24'h0, rotate, 3'h0, prio_en} :
                         rd_is_ccr ? {24'h0, ccr_view} :
                         rd_is_bcr ? {16'h0, bcount[rd_ch]} :
                         rd_is_adr ? {16'h0, xaddr[rd_ch]} : 32'h0;

   // Write side: each channel is taken once and held until the response is accepted.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `DCAS_RESP_OK;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `DCAS_RESP_OK : `DCAS_RESP_ERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Write payload holding registers.
   always_ff @(posedge aclk) begin
      if (s_axi_awvalid && s_axi_awready) begin
         aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_q <= s_axi_wdata;
         ws_q <= s_axi_wstrb;
      end
   end

   // Read side: one read at a time, answered the cycle after the address.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `DCAS_RESP_OK;
      end else if (rd_fire) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_hit ? `DCAS_RESP_OK : `DCAS_RESP_ERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Priority selection.

   wire [3:0] blk_mask = block_own ? 4'b0001 << cur_ch : 4'h0;
   wire [3:0] elig = req_s & prio_en & zero_flag & ~blk_mask;
   wire [2:0] sel = pick(elig, rotate ? rot_ptr : 2'h0);
   wire sel_ok = sel[2];
   wire [1:0] sel_ch = sel[1:0];
   wire cur_ok = prio_en[cur_ch] && zero_flag[cur_ch];
   wire cur_tsc = cfg[cur_ch].three_state_bus_mode;
   wire cur_burst = cfg[cur_ch].burst && !cur_tsc;
   wire last_byte = bcount[cur_ch] == 16'h0001;
   wire in_xfer = state == dcas_pkg::ST_XFER;
   wire latch = (state == dcas_pkg::ST_IDLE || state == dcas_pkg::ST_DEAD) && sel_ok;
   wire [1:0] next_ch = latch ? sel_ch : cur_ch;
   wire [3:0] cur_mask = 4'b0001 << cur_ch;
   wire [3:0] xfer_ch = in_xfer ? cur_mask : 4'h0;
   wire [3:0] done_blk = (in_xfer && last_byte) ? cur_mask & ~wr_bcr : 4'h0;
   wire [3:0] other = req_s & prio_en & zero_flag & ~cur_mask;

   // Sequencer next state.
   always_comb begin
      next_state = state;
      case (state)
         dcas_pkg::ST_IDLE: begin
            if (sel_ok) begin
               next_state = dcas_pkg::ST_REQ;
            end
         end
         dcas_pkg::ST_REQ: begin
            if (!cur_ok) begin
               next_state = dcas_pkg::ST_GAP;
            end else if (grant_s && req_s[cur_ch]) begin
               next_state = dcas_pkg::ST_XFER;
            end
         end
         dcas_pkg::ST_XFER: begin
            if (cur_burst && !last_byte) begin
               next_state = dcas_pkg::ST_REQ;
            end else if (!cur_tsc && (|other)) begin
               next_state = dcas_pkg::ST_DEAD;
            end else begin
               next_state = dcas_pkg::ST_GAP;
            end
         end
         dcas_pkg::ST_DEAD: begin
            next_state = (sel_ok && !cfg[sel_ch].three_state_bus_mode) ? dcas_pkg::ST_REQ : dcas_pkg::ST_GAP;
         end
         dcas_pkg::ST_GAP: begin
            next_state = dcas_pkg::ST_IDLE;
         end
         default: begin
            next_state = dcas_pkg::ST_IDLE;
         end
      endcase
   end

   // A request line stays asserted through request, transfer and dead cycles.
   wire next_act = next_state == dcas_pkg::ST_REQ || next_state == dcas_pkg::ST_XFER ||
                   next_state == dcas_pkg::ST_DEAD;
   wire next_tsc = cfg[next_ch].three_state_bus_mode && next_state != dcas_pkg::ST_DEAD;
   wire next_xfer = next_state == dcas_pkg::ST_XFER;

   // Sequencer registers.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= dcas_pkg::ST_IDLE;
         cur_ch <= 2'h0;
         rot_ptr <= `DCAS_ROT_RST;
         block_own <= 1'b0;
      end else begin
         state <= (state == dcas_pkg::ST_DEAD && !(sel_ok && !cfg[sel_ch].three_state_bus_mode)) ?
                  dcas_pkg::ST_GAP : next_state;
         cur_ch <= (latch && !(state == dcas_pkg::ST_DEAD && cfg[sel_ch].three_state_bus_mode)) ?
                   sel_ch : cur_ch;
         if (latch && rotate) begin
            rot_ptr <= sel_ch + 2'h1;
         end
         block_own <= in_xfer ? 1'b1 : (state == dcas_pkg::ST_IDLE ? 1'b0 : block_own);
      end
   end

   // Pin outputs, all registered.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         halt_bus_request_n <= 1'b1;
         tsc_bus_request_n <= 1'b1;
         tsc_bus_request_out <= 1'b0;
         transfer_strobe <= 1'b0;
         transfer_ack_b <= '0;
         dma_bus <= '0;
      end else begin
         halt_bus_request_n <= !(next_act && !next_tsc);
         tsc_bus_request_n <= !(next_act && next_tsc);
         tsc_bus_request_out <= next_act && next_tsc;
         transfer_strobe <= next_xfer;
         transfer_ack_b <= next_xfer ? 4'b0001 << cur_ch : 4'h0;
         dma_bus.addr <= xaddr[cur_ch];
         dma_bus.rw <= cfg[cur_ch].rw;
         dma_bus.oe <= next_xfer;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control registers and flags.

   // Priority control and channel configuration.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prio_en <= `DCAS_PCR_RST;
         rotate <= 1'b0;
         for (int i = 0; i < NCH; i++) begin
            cfg[i] <= '0;
         end
      end else begin
         if (wr_pcr && ws_q[0]) begin
            prio_en <= w_q[3:0];
            rotate <= w_q[`DCAS_ROT_BIT];
         end
         for (int i = 0; i < NCH; i++) begin
            if (wr_ccr[i] && ws_q[0]) begin
               cfg[i] <= w_q[3:0];
            end
         end
      end
   end

   // Status flags; in the same cycle a count write beats the zero-count clear, a busy clear beats its set, and end set beats a read clear.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         zero_flag <= '0;
         busy <= '0;
         end_flag <= '0;
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (wr_bcr[i]) begin
               zero_flag[i] <= |merge16(bcount[i], w_q, ws_q);
            end else if (done_blk[i]) begin
               zero_flag[i] <= 1'b0;
            end
            if (!prio_en[i] || done_blk[i]) begin
               busy[i] <= 1'b0;
            end else if (latch && sel_ch == 2'(i)) begin
               busy[i] <= 1'b1;
            end
            if (done_blk[i]) begin
               end_flag[i] <= 1'b1;
            end else if (rd_ccr[i]) begin
               end_flag[i] <= 1'b0;
            end
         end
      end
   end

   // Counts and addresses are data and keep their contents through reset.
   always_ff @(posedge aclk) begin
      for (int i = 0; i < NCH; i++) begin
         if (wr_bcr[i]) begin
            bcount[i] <= merge16(bcount[i], w_q, ws_q);
         end else if (xfer_ch[i]) begin
            bcount[i] <= bcount[i] - 16'h0001;
         end
         if (wr_adr[i]) begin
            xaddr[i] <= merge16(xaddr[i], w_q, ws_q);
         end else if (xfer_ch[i]) begin
            xaddr[i] <= cfg[i].up_down ? xaddr[i] - 16'h0001 : xaddr[i] + 16'h0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_tsc_req;
      transfer_strobe && tsc_bus_request_out |-> halt_bus_request_n;
   endproperty
   a_tsc_req: assert property (p_tsc_req) else $error("halt request in tsc transfer");

   property p_tsc_out;
      tsc_bus_request_out == !tsc_bus_request_n;
   endproperty
   a_tsc_out: assert property (p_tsc_out) else $error("tsc request lines disagree");

   property p_tsc_release;
      transfer_strobe && tsc_bus_request_out |=> tsc_bus_request_n ##1 !transfer_strobe;
   endproperty
   a_tsc_release: assert property (p_tsc_release) else $error("tsc not released");

   property p_gate;
      latch |-> prio_en[sel_ch] && zero_flag[sel_ch];
   endproperty
   a_gate: assert property (p_gate) else $error("ungated request accepted");

   property p_wait_req;
      $rose(transfer_strobe) |-> $past(req_s[cur_ch]) && $past(grant_s);
   endproperty
   a_wait_req: assert property (p_wait_req) else $error("byte without request");

   property p_block;
      latch && block_own |-> sel_ch != cur_ch;
   endproperty
   a_block: assert property (p_block) else $error("own request not blocked");

   property p_fixed;
      latch && !rotate |-> (elig & ((4'b0001 << sel_ch) - 4'h1)) == 4'h0;
   endproperty
   a_fixed: assert property (p_fixed) else $error("fixed priority broken");

   // Only a halt-to-halt change must keep the bus; a three-state successor may release it.
   property p_dead;
      in_xfer && !cur_tsc && next_state == dcas_pkg::ST_DEAD ##1 (sel_ok && !cfg[sel_ch].three_state_bus_mode)
         |-> !halt_bus_request_n ##1 !halt_bus_request_n;
   endproperty
   a_dead: assert property (p_dead) else $error("halt released on change");

   property p_busy_end;
      |done_blk |=> (busy & $past(cur_mask)) == 4'h0 && (end_flag & $past(cur_mask)) != 4'h0;
   endproperty
   a_busy_end: assert property (p_busy_end) else $error("block end flags wrong");

   property p_busy_en;
      ##1 (busy & ~$past(prio_en)) == 4'h0;
   endproperty
   a_busy_en: assert property (p_busy_en) else $error("busy with enable low");

endmodule : dcas_top

// File: verif/dcas_far_model.sv
////////////////////////////////////////
// Peripherals and bus grant source facing the controller.
module dcas_far_model (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Bench controls: one-cycle raise, held level, slow grant.
   input wire logic [3:0] pulse,
   input wire logic [3:0] hold,
   input wire logic slow,
   // Controller side.
   input wire logic halt_bus_request_n,
   input wire logic tsc_bus_request_n,
   input wire logic transfer_strobe,
   input wire logic [3:0] transfer_ack_b,
   output logic [3:0] channel_request,
   output logic bus_grant_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] pend;
   logic [3:0] gsr;

   // A peripheral lowers its request once its byte has been strobed.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pend <= 4'h0;
      end else begin
         pend <= (pend | pulse) & ~(transfer_strobe ? transfer_ack_b : 4'h0);
      end
   end
   assign channel_request = pend | hold;

   // grant answers request
   // Grant follows either request after one or four cycles and drops one cycle after it.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gsr <= 4'h0;
      end else begin
         gsr <= {gsr[2:0], ~(halt_bus_request_n & tsc_bus_request_n)};
      end
   end
   assign bus_grant_in = slow ? (&gsr) : gsr[0];
endmodule : dcas_far_model

// File: verif/dcas_tb_top.sv
////////////////////////////////////////
module dcas_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [7:0] a;
      logic [31:0] d;
      logic [31:0] q;
      logic [1:0] r;
   } dcas_row_s;
   localparam logic [7:0] PRIO_A = 8'h00;
   localparam logic [7:0] CTRL_A = 8'h10;
   localparam logic [7:0] CNT_A = 8'h20;
   localparam logic [7:0] ADDR_A = 8'h30;
   logic aclk, aresetn, slow;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb, channel_request, transfer_ack_b, pulse, hold;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic transfer_strobe, bus_grant_in, halt_bus_request_n, tsc_bus_request_n;
   logic tsc_bus_request_out, s_halt, s_tsc, s_out;
   logic [15:0] s_addr;
   dcas_pkg::dcas_bus_s dma_bus;
   int error_cnt, num_checks, cyc, nstrb, tgt, hi_cnt;
   logic [3:0] seen_q[$];
   logic [3:0] rot_q [8] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h1, 4'h2, 4'h4, 4'h8};
   logic [3:0] nrm_q [8] = '{4'h1, 4'h2, 4'h1, 4'h2, 4'h4, 4'h8, 4'h4, 4'h8};
   // Flag bits written as ones must read back as zero.
   dcas_row_s rows [5] = '{
      '{PRIO_A, 32'h8f, 32'h8f, 2'b00},
      '{CTRL_A + 8'h04, 32'hcf, 32'h0f, 2'b00},
      '{CNT_A + 8'h08, 32'habcd, 32'habcd, 2'b00},
      '{ADDR_A + 8'h0c, 32'h1357, 32'h1357, 2'b00},
      '{8'hf0, 32'h1, 32'h0, 2'b10}};

   dcas_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .channel_request(channel_request),
      .transfer_ack_b(transfer_ack_b), .transfer_strobe(transfer_strobe),
      .bus_grant_in(bus_grant_in), .halt_bus_request_n(halt_bus_request_n),
      .tsc_bus_request_n(tsc_bus_request_n), .tsc_bus_request_out(tsc_bus_request_out),
      .dma_bus(dma_bus));

   dcas_far_model FAR (.aclk(aclk), .aresetn(aresetn), .pulse(pulse), .hold(hold),
      .slow(slow), .halt_bus_request_n(halt_bus_request_n),
      .tsc_bus_request_n(tsc_bus_request_n), .transfer_strobe(transfer_strobe),
      .transfer_ack_b(transfer_ack_b), .channel_request(channel_request),
      .bus_grant_in(bus_grant_in));

   // Free-running 100 MHz clock.
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   ////////////////////////////////////////
   // Records strobed bytes and counts cycles with the bus back at the processor.
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (transfer_strobe === 1'b1) begin
         seen_q.push_back(transfer_ack_b);
         s_addr <= dma_bus.addr;
         {s_halt, s_tsc, s_out} <= {halt_bus_request_n, tsc_bus_request_n, tsc_bus_request_out};
         nstrb <= nstrb + 1;
      end
      if (nstrb > 0 && nstrb < tgt && (halt_bus_request_n & tsc_bus_request_n) === 1'b1) begin
         hi_cnt <= hi_cnt + 1;
      end
      // A hang would otherwise stall the run forever.
      if (cyc == 20000) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t timeout", $time);
         report_and_stop();
      end
   end

   task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
      num_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t %s", $time, m);
      end
   endtask : chk

   // Each bus task starts one edge later so no signal is driven twice in one step.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      {s_axi_awaddr, s_axi_wdata} <= {a, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      forever begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) break;
      end
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr

   task automatic rdr(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      forever begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) break;
      end
      {rd, resp} = {s_axi_rdata, s_axi_rresp};
      s_axi_rready <= 1'b0;
   endtask : rdr

   task automatic do_reset();
      aresetn <= 1'b0;
      {pulse, hold} <= 8'h00;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      {nstrb, tgt, hi_cnt} = {32'd0, 32'd0, 32'd0};
      seen_q.delete();
   endtask : do_reset

   task automatic setup(input int c, input logic [7:0] cfg, input logic [15:0] n);
      wr(CTRL_A + 8'(4 * c), 32'(cfg));
      wr(ADDR_A + 8'(4 * c), 32'h0100);
      wr(CNT_A + 8'(4 * c), 32'(n));
   endtask : setup

   task automatic req(input logic [3:0] m);
      @(posedge aclk);
      pulse <= m;
      @(posedge aclk);
      pulse <= 4'h0;
   endtask : req

   task automatic wait_strb(input int n);
      while (nstrb < n) @(posedge aclk);
   endtask : wait_strb

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : report_and_stop

   ////////////////////////////////////////
   // Main sequence.
   initial begin
      {aresetn, slow, pulse, hold, s_axi_wstrb} = {2'b00, 4'h0, 4'h0, 4'hf};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {error_cnt, num_checks, cyc} = {32'd0, 32'd0, 32'd0};
      do_reset();
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         chk(32'(resp), 32'(rows[i].r), "write response");
         rdr(rows[i].a);
         chk(rd, rows[i].q, "read data");
         chk(32'(resp), 32'(rows[i].r), "read response");
      end
      $display("test registers done");
      do_reset();
      rdr(CNT_A + 8'h08);
      chk(rd, 32'habcd, "count kept over reset");
      wr(PRIO_A, 32'h04);
      hold <= 4'h4;
      repeat (30) @(posedge aclk);
      chk(32'(nstrb), 32'd0, "request taken with zero count");
      chk(32'(halt_bus_request_n), 32'd1, "bus requested with zero count");
      hold <= 4'h0;
      $display("test zero count done");
      setup(0, 8'h00, 16'h0002);
      wr(PRIO_A, 32'h01);
      req(4'h1);
      wait_strb(1);
      chk(32'({s_halt, s_tsc}), 32'h1, "halt side request");
      chk(32'({seen_q[0], s_addr}), 32'h10100, "ack and address");
      repeat (6) @(posedge aclk);
      chk(32'(halt_bus_request_n), 32'd1, "bus kept between bytes");
      rdr(CTRL_A);
      chk(rd, 32'h40, "busy set");
      req(4'h1);
      wait_strb(2);
      chk(32'(s_addr), 32'h0101, "address step");
      repeat (6) @(posedge aclk);
      rdr(CTRL_A);
      chk(rd, 32'h80, "end flag set, busy clear");
      rdr(CTRL_A);
      chk(rd, 32'h00, "end flag cleared by read");
      hold <= 4'h1;
      repeat (20) @(posedge aclk);
      chk(32'(nstrb), 32'd2, "request after count reached zero");
      hold <= 4'h0;
      $display("test halt steal done");
      slow <= 1'b1;
      {nstrb, tgt, hi_cnt} = {32'd0, 32'd2, 32'd0};
      setup(1, 8'h06, 16'h0002);
      wr(PRIO_A, 32'h02);
      hold <= 4'h2;
      wait_strb(2);
      chk(32'({s_halt, s_tsc, s_out}), 32'h5, "three-state request lines");
      chk(32'(hi_cnt > 0), 32'd1, "no release between three-state bytes");
      hold <= 4'h0;
      slow <= 1'b0;
      rdr(CTRL_A + 8'h04);
      chk(rd, 32'h86, "three-state block end");
      {nstrb, tgt, hi_cnt} = {32'd0, 32'd3, 32'd0};
      setup(2, 8'h02, 16'h0003);
      wr(PRIO_A, 32'h04);
      hold <= 4'h4;
      wait_strb(3);
      chk(32'(hi_cnt), 32'd0, "burst released the bus");
      hold <= 4'h0;
      rdr(CTRL_A + 8'h08);
      chk(rd, 32'h82, "burst block end");
      nstrb = 0;
      setup(3, 8'h00, 16'h0002);
      wr(PRIO_A, 32'h08);
      req(4'h8);
      wait_strb(1);
      wr(PRIO_A, 32'h00);
      rdr(CTRL_A + 8'h0c);
      chk(rd, 32'h00, "busy kept with enable low");
      $display("test modes done");
      // Rotate first so the pointer starts from its reset value.
      for (int m = 0; m < 2; m++) begin
         do_reset();
         tgt = 8;
         for (int c = 0; c < 4; c++) setup(c, 8'h00, 16'h0002);
         wr(PRIO_A, m == 0 ? 32'h8f : 32'h0f);
         hold <= 4'hf;
         wait_strb(8);
         hold <= 4'h0;
         foreach (rot_q[i]) chk(32'(seen_q[i]), 32'(m == 0 ? rot_q[i] : nrm_q[i]), "order");
         chk(32'(hi_cnt), 32'd0, "halt released on channel change");
      end
      $display("test priority done");
      report_and_stop();
   end
endmodule : dcas_tb_top
